// file: rtl/asq_port.sv
/*
  Digital control side of a four-channel simultaneous-sampling converter.
  Assumes all pins asynchronous to ref_clk; the analog core hands in one
  result per converted channel through conv_code.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Hardware mode: shared pin is channel 2 include
// - Include pins captured at conversion start rise
// - Software mode ignores include pins
// - Include high adds channel, low omits
// - Hardware mode: pins select, internal clock
// - Software mode: register selects, either clock
// - Standby low blocks new starts, powers down once idle; high runs normally
// - Result on 14-bit three-state bus
// - Two's complement bipolar, binary unipolar
// - Low four lines: read outputs, write inputs
// - Register bit 0 channel 1, bit 3 channel 4
// - Low end pulse after each channel
// - Write strobe rise loads register
// - Start rise holds all, begins conversion
// - Busy from start until sequence done
// - Drive bus only when read and select low
module asq_port
  import asq_pkg::*;
#(
  parameter bit UNIPOLAR = 1'b0
)(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  conversion_start_in,
  input  wire logic                  hw_sw_select,
  input  wire logic                  standby_n,
  input  wire logic                  clkin_include_ch1_pin,
  input  wire logic                  clksrc_include_ch2_pin,
  input  wire logic                  include_ch3_pin,
  input  wire logic                  include_ch4_pin,
  input  wire logic                  ext_conv_clk,
  input  wire asq_pkg::asq_bus_t     host_bus,
  input  wire logic [asq_pkg::DATA_W-1:0] conv_code,
  output logic [asq_pkg::DATA_W-1:0] result_bus_out,
  output logic [asq_pkg::DATA_W-1:0] result_bus_oe,
  output logic                       busy,
  output logic                       eoc_n,
  output logic                       hold_all,
  output logic                       powered_down
);
  import asq_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int SW = 12;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] pin_raw;
  assign pin_raw = {conversion_start_in, hw_sw_select, standby_n,
                    clkin_include_ch1_pin, clksrc_include_ch2_pin,
                    include_ch3_pin, include_ch4_pin, ext_conv_clk,
                    host_bus.cs_n, host_bus.rd_n, host_bus.wr_n, 1'b0};
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1_reg <= 12'hE2E;
      s2_reg <= 12'hE2E;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
    end
  end

  logic [3:0] db_s1_reg;
  logic [3:0] db_s2_reg;
  always_ff @(posedge ref_clk)
  begin
    db_s1_reg <= host_bus.db_lo;
    db_s2_reg <= db_s1_reg;
  end

  wire cst_s   = s2_reg[11];
  wire sw_mode = s2_reg[10];
  wire standby_n_s  = s2_reg[9];
  wire p1_s    = s2_reg[8];
  wire p2_s    = s2_reg[7];
  wire p3_s    = s2_reg[6];
  wire p4_s    = s2_reg[5];
  wire cs_s    = s2_reg[3];
  wire rd_s    = s2_reg[2];
  wire wr_s    = s2_reg[1];

  logic cst_d_reg;
  logic wr_d_reg;
  logic eclk_d_reg;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cst_d_reg  <= 1'b1;
      wr_d_reg   <= 1'b1;
      eclk_d_reg <= 1'b0;
    end
    else
    begin
      cst_d_reg  <= cst_s;
      wr_d_reg   <= wr_s;
      eclk_d_reg <= p1_s;
    end
  end
  wire cst_rise  = cst_s & ~cst_d_reg;
  wire wr_rise   = wr_s & ~wr_d_reg;
  wire eclk_rise = p1_s & ~eclk_d_reg;

  // ------------------------------------------------------------
  // Channel select register
  // ------------------------------------------------------------
  logic [3:0] chsel_reg;
  wire        chsel_load = wr_rise & ~cs_s & rd_s;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      chsel_reg <= CHSEL_RESET;
    else if (chsel_load)
      chsel_reg <= db_s2_reg;
  end

  // ------------------------------------------------------------
  // Sequence selection and clock source
  // ------------------------------------------------------------
  wire [3:0] hw_set  = {p4_s, p3_s, p2_s, p1_s};
  wire [3:0] sel_now = sw_mode ? chsel_reg : hw_set;
  wire       use_ext = sw_mode & p2_s;

  logic [1:0] idiv_reg;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      idiv_reg <= 2'h0;
    else
      idiv_reg <= (idiv_reg == 2'(INT_DIV - 1)) ? 2'h0 : idiv_reg + 2'h1;
  end
  logic ext_latched_reg;
  wire  tick = ext_latched_reg ? eclk_rise : (idiv_reg == 2'h0);

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  asq_state_t st_reg;
  logic [3:0] pend_reg;
  logic [1:0] ch_reg;
  logic [4:0] bit_cnt_reg;
  logic [2:0] eoc_cnt_reg;

  wire [1:0] first_ch = pend_reg[0] ? 2'd0 : pend_reg[1] ? 2'd1 :
                        pend_reg[2] ? 2'd2 : 2'd3;
  wire start_ok = cst_rise & standby_n_s & (st_reg == ASQ_IDLE);

  // Two-entry result buffer
  asq_word_t buf_mem [2];
  logic [1:0] buf_cnt_reg;
  logic       wp_reg;
  logic       rp_reg;
  wire  buf_ready = (buf_cnt_reg != 2'd2);
  wire  push      = (st_reg == ASQ_CONV) & (bit_cnt_reg == 5'(CONV_CLKS)) & buf_ready;
  wire  rd_active = ~cs_s & ~rd_s;
  logic rd_d_reg;
  wire  pop       = rd_d_reg & ~rd_active & (buf_cnt_reg != 2'd0);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_reg          <= ASQ_IDLE;
      pend_reg        <= 4'h0;
      ch_reg          <= 2'd0;
      bit_cnt_reg     <= 5'd0;
      eoc_cnt_reg     <= 3'd0;
      ext_latched_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        ASQ_IDLE:
          if (start_ok && sel_now != 4'h0)
          begin
            pend_reg        <= sel_now;
            ext_latched_reg <= use_ext;
            st_reg          <= ASQ_PICK;
          end
        ASQ_PICK:
        begin
          ch_reg      <= first_ch;
          pend_reg    <= pend_reg & ~(4'h1 << first_ch);
          bit_cnt_reg <= 5'd0;
          st_reg      <= ASQ_CONV;
        end
        ASQ_CONV:
          if (push)
          begin
            eoc_cnt_reg <= 3'(EOC_PULSE_CYC);
            st_reg      <= ASQ_EOC;
          end
          else if (tick && bit_cnt_reg != 5'(CONV_CLKS))
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
        ASQ_EOC:
          if (eoc_cnt_reg == 3'd1)
            st_reg <= (pend_reg == 4'h0) ? ASQ_IDLE : ASQ_PICK;
          else
            eoc_cnt_reg <= eoc_cnt_reg - 3'd1;
        default:
          st_reg <= ASQ_IDLE;
      endcase
    end
  end

  wire [DATA_W-1:0] coded = UNIPOLAR ? conv_code
                          : {~conv_code[DATA_W-1], conv_code[DATA_W-2:0]};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      buf_cnt_reg <= 2'd0;
      wp_reg      <= 1'b0;
      rp_reg      <= 1'b0;
      rd_d_reg    <= 1'b0;
    end
    else
    begin
      rd_d_reg <= rd_active;
      if (push)
      begin
        buf_mem[wp_reg] <= '{ch: ch_reg, code: coded};
        wp_reg          <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy           <= 1'b0;
      eoc_n          <= 1'b1;
      hold_all       <= 1'b0;
      powered_down   <= 1'b0;
      result_bus_out <= '0;
      result_bus_oe  <= '0;
    end
    else
    begin
      busy           <= (st_reg != ASQ_IDLE) | (start_ok & sel_now != 4'h0);
      hold_all       <= (st_reg != ASQ_IDLE) | (start_ok & sel_now != 4'h0);
      eoc_n          <= ~(st_reg == ASQ_EOC);
      powered_down   <= ~standby_n_s & (st_reg == ASQ_IDLE);
      result_bus_out <= buf_mem[rp_reg].code;
      result_bus_oe  <= {DATA_W{rd_active & wr_s}};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_busy_rise;
    @(posedge ref_clk) disable iff (sys_rst)
      (start_ok && sel_now != 4'h0) |=> busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_busy_end;
    @(posedge ref_clk) disable iff (sys_rst)
      (st_reg == ASQ_IDLE && !start_ok) |=> !busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");

  property p_eoc_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(st_reg == ASQ_EOC) |=> !eoc_n;
  endproperty
  a_eoc_pulse: assert property (p_eoc_pulse) else $error("no end pulse");

  property p_load;
    @(posedge ref_clk) disable iff (sys_rst)
      chsel_load |=> chsel_reg == $past(db_s2_reg);
  endproperty
  a_load: assert property (p_load) else $error("register not loaded");

  property p_hold_reg;
    @(posedge ref_clk) disable iff (sys_rst)
      !chsel_load |=> $stable(chsel_reg);
  endproperty
  a_hold_reg: assert property (p_hold_reg) else $error("register changed");

  property p_oe;
    @(posedge ref_clk) disable iff (sys_rst)
      (cs_s || rd_s) |=> result_bus_oe == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven when not read");

  property p_capture;
    @(posedge ref_clk) disable iff (sys_rst)
      (start_ok && sel_now != 4'h0) |=> pend_reg == $past(sel_now);
  endproperty
  a_capture: assert property (p_capture) else $error("set not captured");

  property p_standby;
    @(posedge ref_clk) disable iff (sys_rst)
      (!standby_n_s && st_reg == ASQ_IDLE) |=> st_reg == ASQ_IDLE;
  endproperty
  a_standby: assert property (p_standby) else $error("started in standby");

  property p_sw_ignore;
    @(posedge ref_clk) disable iff (sys_rst)
      (start_ok && sw_mode && chsel_reg != 4'h0) |=> pend_reg == $past(chsel_reg);
  endproperty
  a_sw_ignore: assert property (p_sw_ignore) else $error("pins used in sw mode");

  c_seq:   cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(busy));
  c_write: cover property (@(posedge ref_clk) disable iff (sys_rst) chsel_load);
  c_full:  cover property (@(posedge ref_clk) disable iff (sys_rst) buf_cnt_reg == 2'd2);
endmodule

`default_nettype wire

// file: rtl/asq_pkg.sv
/*
  Package for the converter sequence/select port: constants, types.
  Assumes one 50 MHz clock domain, synchronous active-high reset.
*/
package asq_pkg;
  localparam int unsigned DATA_W        = 14;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned CONV_CLKS     = 16;
  localparam int unsigned EOC_PULSE_NS  = 40;
  localparam int unsigned EOC_PULSE_CYC =
    (EOC_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned INT_DIV       = 2;
  localparam logic [3:0]  CHSEL_RESET   = 4'hF;
  localparam int unsigned CH_FIELD_LSB  = 0;

  typedef enum logic [1:0] {ASQ_IDLE, ASQ_CONV, ASQ_EOC, ASQ_PICK} asq_state_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] db_lo;
  } asq_bus_t;

  typedef struct packed {
    logic [1:0]        ch;
    logic [DATA_W-1:0] code;
  } asq_word_t;
endpackage

// file: testbench/asq_host_model.sv
/*
  Host bus model: drives select, strobes and low data lines.
  Assumes ref_clk at 50 MHz; the bench calls wr and rd.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_host_model
  import asq_pkg::*;
(
  input  wire logic                         ref_clk,
  input  wire logic [asq_pkg::DATA_W-1:0]   bus_out,
  input  wire logic [asq_pkg::DATA_W-1:0]   bus_oe,
  output var  asq_pkg::asq_bus_t            host_bus
);
  initial host_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, db_lo: 4'hA};

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Write, read strobe high; refused form keeps select high
  task automatic wr(input logic [3:0] d, input logic refuse);
    host_bus.cs_n  = refuse;
    host_bus.db_lo = d;
    step(4);
    host_bus.wr_n = 1'b0;
    step(4);
    host_bus.wr_n = 1'b1;
    step(4);
    host_bus.cs_n  = 1'b1;
    host_bus.db_lo = ~d;
    step(4);
  endtask

  // Read with write strobe held high
  task automatic rd(output logic [DATA_W-1:0] d, output logic [DATA_W-1:0] oe);
    host_bus.cs_n = 1'b0;
    host_bus.rd_n = 1'b0;
    step(5);
    d  = bus_out;
    oe = bus_oe;
    host_bus.rd_n = 1'b1;
    host_bus.cs_n = 1'b1;
    step(5);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_asq_port.sv
/*
  Self-checking bench for the converter port.
  Assumes the host model; the analog core is a constant code.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_asq_port;
  import asq_pkg::*;
  logic              ref_clk, sys_rst, cst, hw_sw, standby_n_n, busy, eoc_n, hold_all, pdn;
  logic [3:0]        pins;
  logic [DATA_W-1:0] code, bus_out, bus_oe, rdat, roe;
  asq_bus_t          hbus;
  int                failures, checks, eocs;

  asq_port asq_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .conversion_start_in(cst), .hw_sw_select(hw_sw), .standby_n(standby_n_n),
    .clkin_include_ch1_pin(pins[0]), .clksrc_include_ch2_pin(pins[1]),
    .include_ch3_pin(pins[2]), .include_ch4_pin(pins[3]), .ext_conv_clk(1'b0),
    .host_bus(hbus), .conv_code(code), .result_bus_out(bus_out),
    .result_bus_oe(bus_oe), .busy(busy), .eoc_n(eoc_n), .hold_all(hold_all),
    .powered_down(pdn));
  asq_host_model asq_host_model_inst (.ref_clk(ref_clk), .bus_out(bus_out),
    .bus_oe(bus_oe), .host_bus(hbus));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Count end pulses and measure each width
  always @(negedge eoc_n)
  begin : eoc_watch
    int w;
    w = 0;
    eocs++;
    while (eoc_n === 1'b0)
    begin
      step(1);
      w++;
    end
    chk(w, EOC_PULSE_CYC);
  end

  // Start, change pins after the latch, wait for busy to drop
  task automatic run(input logic [3:0] late, input int n_exp);
    int k;
    eocs = 0;
    cst = 1'b1;
    step(6);
    chk(busy, 1'b1);
    chk(hold_all, 1'b1);
    pins = late;
    k = 0;
    while (busy === 1'b1 && k < 2000)
    begin
      step(1);
      k++;
    end
    chk(k < 2000, 1'b1);
    cst = 1'b0;
    step(4);
    chk(eocs, n_exp);
  endtask

  // Read back results; bipolar coding flips the top bit
  task automatic drain(input int n);
    repeat (n)
    begin
      asq_host_model_inst.rd(rdat, roe);
      chk(roe, {DATA_W{1'b1}});
      chk(rdat, code ^ 14'h2000);
      chk(bus_oe, 14'h0000);
    end
  endtask

  task automatic t_reset;
    chk(busy, 1'b0);
    chk(eoc_n, 1'b1);
    chk(bus_oe, 14'h0000);
    $display("test reset done");
  endtask

  task automatic t_hw;
    hw_sw = 1'b0;
    pins = 4'h5;
    run(4'hF, 2);
    drain(2);
    pins = 4'h2;
    run(4'h0, 1);
    drain(1);
    $display("test hardware select done");
  endtask

  task automatic t_sw;
    hw_sw = 1'b1;
    pins = 4'hC;
    asq_host_model_inst.wr(4'h8, 1'b0);
    asq_host_model_inst.wr(4'h7, 1'b1);
    run(4'hC, 1);
    drain(1);
    $display("test register select done");
  endtask

  // External clock on the shared pin; conversion stands still until clocked
  task automatic t_ext;
    eocs = 0;
    pins = 4'h2;
    step(4);
    cst = 1'b1;
    step(60);
    chk(busy, 1'b1);
    repeat (16)
    begin
      pins[0] = 1'b1;
      step(4);
      pins[0] = 1'b0;
      step(4);
    end
    step(4);
    chk(busy, 1'b0);
    chk(eocs, 1);
    cst = 1'b0;
    pins = 4'h0;
    step(4);
    drain(1);
    $display("test external clock done");
  endtask

  task automatic t_standby_n;
    standby_n_n = 1'b0;
    step(6);
    chk(pdn, 1'b1);
    cst = 1'b1;
    step(8);
    chk(busy, 1'b0);
    cst = 1'b0;
    standby_n_n = 1'b1;
    step(6);
    chk(pdn, 1'b0);
    $display("test standby done");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    cst = 1'b0;
    hw_sw = 1'b0;
    standby_n_n = 1'b1;
    pins = 4'h0;
    code = 14'h0123;
    failures = 0;
    checks = 0;
    eocs = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    step(4);
    t_reset;
    t_hw;
    t_sw;
    t_ext;
    t_standby_n;
    summarize;
  end

  initial
  begin
    #400000;
    failures++;
    summarize;
  end
endmodule
`default_nettype wire
